// file: logic/ccp_pkg.sv
// Constants shared by the capture/compare/PWM unit
package ccp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h0C;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h0D;
  localparam logic [7:0] IDX_ONE_LOW = 8'h15;
  localparam logic [7:0] IDX_ONE_HIGH = 8'h16;
  localparam logic [7:0] IDX_ONE_CTRL = 8'h17;
  localparam logic [7:0] IDX_TWO_LOW = 8'h1B;
  localparam logic [7:0] IDX_TWO_HIGH = 8'h1C;
  localparam logic [7:0] IDX_TWO_CTRL = 8'h1D;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  // Flag register fields
  localparam int FLAG_CH1_BIT = 2;
  localparam int FLAG_T1_BIT = 0;
  localparam int FLAG_CH2_BIT = 0;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FINE_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Mode encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  // Prescaler terminal counts
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {CLS_OFF, CLS_CAP, CLS_CMP, CLS_PWM} chan_cls_t;
endpackage

// file: logic/ccp_unit.sv
// Two-channel capture/compare/PWM unit with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none

module ccp_channel
  import ccp_pkg::*;
#(
  parameter bit HAS_ADC = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  input wire logic [15:0] first_timer,
  input wire logic [7:0] t2_value,
  input wire logic [1:0] t2_fine,
  input wire logic t2_wrap,
  input wire logic wr_ctrl,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic wr_flag,
  input wire logic [7:0] wdata,
  input wire logic flag_wbit,
  output logic [5:0] ctrl_q,
  output logic [7:0] low_q,
  output logic [7:0] high_q,
  output logic flag_q,
  output logic pin_out_q,
  output logic pin_oe_q,
  output logic trig_q
);
  logic sync1_q, sync2_q, sync3_q;
  logic [3:0] pre_q;
  logic match_prev_q;
  logic [1:0] fine_lat_q;
  logic [3:0] mode;
  chan_cls_t cls;
  logic rise, fall, cap_evt, match, cmp_evt;
  logic [9:0] duty_next, duty_lat;

  assign mode = ctrl_q[CTRL_MODE_LSB +: 4];
  assign duty_next = {low_q, ctrl_q[CTRL_FINE_LSB +: 2]};
  assign duty_lat = {high_q, fine_lat_q};

  always_comb begin
    case (mode[3:2])
      2'b01: cls = CLS_CAP;
      2'b10: cls = CLS_CMP;
      2'b11: cls = CLS_PWM;
      default: cls = CLS_OFF;
    endcase
  end

  // Pin synchroniser; edges seen only past the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign rise = sync2_q && !sync3_q;
  assign fall = !sync2_q && sync3_q;

  // Prescaler counts every rising edge, kept across capture modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 4'h0;
    end else if (cls != CLS_CAP) begin
      pre_q <= 4'h0;
    end else if (rise) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_comb begin
    case (mode)
      MODE_CAP_FALL: cap_evt = fall;
      MODE_CAP_RISE: cap_evt = rise;
      MODE_CAP_RISE4: cap_evt = rise && pre_q[1:0] == PRE4_LAST[1:0];
      MODE_CAP_RISE16: cap_evt = rise && pre_q == PRE16_LAST;
      default: cap_evt = 1'b0;
    endcase
  end

  assign match = {high_q, low_q} == first_timer;
  assign cmp_evt = cls == CLS_CMP && match && !match_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match && cls == CLS_CMP;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata[5:0];
    end
  end

  // Low byte: capture or software; it holds the next duty in PWM mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= DATA_RESET;
    end else if (cap_evt) begin
      low_q <= first_timer[7:0];
    end else if (wr_low) begin
      low_q <= wdata;
    end
  end

  // High byte: capture, or the active duty latched each period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_q <= DATA_RESET;
      fine_lat_q <= 2'h0;
    end else if (cap_evt) begin
      high_q <= first_timer[15:8];
    end else if (cls == CLS_PWM && t2_wrap) begin
      high_q <= low_q;
      fine_lat_q <= ctrl_q[CTRL_FINE_LSB +: 2];
    end else if (wr_high && cls != CLS_PWM) begin
      high_q <= wdata;
    end
  end

  // Flag: a hardware event wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (cap_evt || cmp_evt) begin
      flag_q <= 1'b1;
    end else if (wr_flag) begin
      flag_q <= flag_wbit;
    end
  end

  // Output latch for compare and PWM
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= 1'b0;
    end else if (wr_ctrl && wdata == 8'h00) begin
      pin_out_q <= 1'b0;
    end else if (cmp_evt && mode == MODE_CMP_SET) begin
      pin_out_q <= 1'b1;
    end else if (cmp_evt && mode == MODE_CMP_CLR) begin
      pin_out_q <= 1'b0;
    end else if (cls == CLS_PWM && t2_wrap) begin
      pin_out_q <= duty_next != 10'h000;
    end else if (cls == CLS_PWM && duty_lat == {t2_value, t2_fine}) begin
      pin_out_q <= 1'b0;
    end else if (cls == CLS_OFF) begin
      pin_out_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      pin_oe_q <= cls == CLS_CMP || cls == CLS_PWM;
      trig_q <= cmp_evt && mode == MODE_CMP_TRIG;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  cap_copy_a: assert property (cap_evt |=>
    {high_q, low_q} == $past(first_timer))
    else $error("capture did not copy the first timer");
  off_pre_a: assert property (mode == MODE_OFF |=> pre_q == 4'h0)
    else $error("prescaler not cleared while channel off");
  nocap_pre_a: assert property ($past(cls) != CLS_CAP |-> pre_q == 4'h0)
    else $error("prescaler not cleared outside capture");
  cap_four_a: assert property (mode == MODE_CAP_RISE4 && rise
    && pre_q == 4'h1 |-> !cap_evt)
    else $error("quarter-rate capture fired early");
  cmp_high_a: assert property (cmp_evt && mode == MODE_CMP_SET
    && !wr_ctrl |=> pin_out_q && flag_q)
    else $error("compare set action missing");
  cmp_low_a: assert property (cmp_evt && mode == MODE_CMP_CLR
    |=> !pin_out_q && flag_q)
    else $error("compare clear action missing");
  cmp_keep_a: assert property (cmp_evt && mode == MODE_CMP_SOFT
    && !wr_ctrl |=> $stable(pin_out_q) && flag_q)
    else $error("software compare touched the pin");
  trig_pulse_a: assert property (cmp_evt && mode == MODE_CMP_TRIG
    |=> trig_q ##1 !trig_q)
    else $error("special trigger not a single pulse");
  flag_cap_a: assert property (cap_evt |=> flag_q)
    else $error("capture flag not set");
  zero_ctrl_a: assert property (wr_ctrl && wdata == 8'h00
    |=> !pin_out_q)
    else $error("zero control did not force pin low");
  pwm_set_a: assert property (cls == CLS_PWM && t2_wrap && !wr_ctrl
    |=> pin_out_q == $past(duty_next != 10'h000) && high_q == $past(low_q))
    else $error("period wrap set or latch wrong");
  pwm_clr_a: assert property (cls == CLS_PWM && !t2_wrap && !wr_ctrl
    && duty_lat == {t2_value, t2_fine} |=> !pin_out_q)
    else $error("duty match did not clear pin");
endmodule // ccp_channel

// Behaviour
// - A capture copies the full 16-bit first timer into both data bytes.
// - Mode 0000 disables the channel and clears its internal state.
// - Modes 0100-0111 capture on fall, rise, 4th rise, 16th rise.
// - Mode 1000: compare match drives output high and sets flag.
// - Mode 1001: compare match drives output low and sets flag.
// - Mode 1010: compare match only sets the flag, pin unchanged.
// - Mode 1011: match sets flag, resets first timer; channel two starts ADC.
// - Modes 11xx select PWM with up to 10-bit duty.
// - Control bits 5:4 are the low duty bits, used only in PWM.
// - Control bits 7:6 always read as zero.
// - Each capture sets the channel flag; only software clears it.
// - A newer capture overwrites an unread captured value.
// - Prescaler clears when off, outside capture, and on reset.
// - Changing prescale setting keeps the count; a capture may result.
// - Compare watches stored value against first timer; pin and flag act next cycle.
// - Writing zero to control forces the output latch low.
// - Special-trigger timer reset does not set timer overflow flag.
// - Special trigger resets the first timer, giving a programmable period.
// - Capture/compare use first timer; PWM uses the second timer.
// - On period wrap: PWM pin set unless duty zero, duty latched.
// - Duty bytes double-buffered, applied after the current period.
// - PWM pin clears when latched duty equals extended second timer.
module ccp_unit
  import ccp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] first_timer,
  input wire logic first_timer_overflow,
  input wire logic [7:0] second_timer,
  input wire logic [1:0] second_timer_fine,
  input wire logic second_timer_wrap,
  input wire logic adc_enabled,
  input wire logic channel_one_pin_in,
  output logic channel_one_pin_out,
  output logic channel_one_pin_oe,
  input wire logic channel_two_pin_in,
  output logic channel_two_pin_out,
  output logic channel_two_pin_oe,
  output logic first_timer_reset,
  output logic adc_start
);
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q, wr_pend_q, t1_flag_q;
  logic first_timer_reset_q, adc_start_q;
  logic [7:0] addr_q;
  logic [7:0] rd_idx;
  logic [7:0] rd_d;
  logic addr_ok, take;
  logic wr_one_ctrl, wr_one_low, wr_one_high, wr_flags_one;
  logic wr_two_ctrl, wr_two_low, wr_two_high, wr_flags_two;
  logic [5:0] one_ctrl, two_ctrl;
  logic [7:0] one_low, one_high, two_low, two_high;
  logic one_flag, two_flag, one_trig, two_trig;

  assign rd_idx = haddr[IDX_MSB:IDX_LSB];
  assign addr_ok = haddr[31:IDX_MSB+1] == 22'h000000;
  assign take = hsel && hready && htrans == HTRANS_NONSEQ;

  always_comb begin
    rd_d = 8'h00;
    if (addr_ok) begin
      case (rd_idx)
        IDX_FLAGS_ONE: rd_d = {5'h00, one_flag, 1'b0, t1_flag_q};
        IDX_FLAGS_TWO: rd_d = {7'h00, two_flag};
        IDX_ONE_LOW: rd_d = one_low;
        IDX_ONE_HIGH: rd_d = one_high;
        IDX_ONE_CTRL: rd_d = {2'b00, one_ctrl};
        IDX_TWO_LOW: rd_d = two_low;
        IDX_TWO_HIGH: rd_d = two_high;
        IDX_TWO_CTRL: rd_d = {2'b00, two_ctrl};
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Reads: no wait; writes: one wait so a next read sees new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (take) begin
      hreadyout_q <= !hwrite;
      wr_pend_q <= hwrite && addr_ok;
      addr_q <= rd_idx;
      if (!hwrite) begin
        hrdata_q <= {24'h000000, rd_d};
      end
    end else begin
      hreadyout_q <= 1'b1;
      wr_pend_q <= 1'b0;
    end
  end

  assign wr_flags_one = wr_pend_q && addr_q == IDX_FLAGS_ONE;
  assign wr_flags_two = wr_pend_q && addr_q == IDX_FLAGS_TWO;
  assign wr_one_low = wr_pend_q && addr_q == IDX_ONE_LOW;
  assign wr_one_high = wr_pend_q && addr_q == IDX_ONE_HIGH;
  assign wr_one_ctrl = wr_pend_q && addr_q == IDX_ONE_CTRL;
  assign wr_two_low = wr_pend_q && addr_q == IDX_TWO_LOW;
  assign wr_two_high = wr_pend_q && addr_q == IDX_TWO_HIGH;
  assign wr_two_ctrl = wr_pend_q && addr_q == IDX_TWO_CTRL;

  // Overflow flag set by the timer itself or a software write, never the trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_flag_q <= 1'b0;
    end else if (first_timer_overflow) begin
      t1_flag_q <= 1'b1;
    end else if (wr_flags_one) begin
      t1_flag_q <= hwdata[FLAG_T1_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_timer_reset_q <= 1'b0;
      adc_start_q <= 1'b0;
    end else begin
      first_timer_reset_q <= one_trig || two_trig;
      adc_start_q <= two_trig && adc_enabled;
    end
  end

  ccp_channel #(.HAS_ADC(1'b0)) u_one (
    .hclk(hclk), .hresetn(hresetn), .pin_in(channel_one_pin_in),
    .first_timer(first_timer), .t2_value(second_timer),
    .t2_fine(second_timer_fine), .t2_wrap(second_timer_wrap),
    .wr_ctrl(wr_one_ctrl), .wr_low(wr_one_low), .wr_high(wr_one_high),
    .wr_flag(wr_flags_one), .wdata(hwdata[7:0]),
    .flag_wbit(hwdata[FLAG_CH1_BIT]), .ctrl_q(one_ctrl), .low_q(one_low),
    .high_q(one_high), .flag_q(one_flag),
    .pin_out_q(channel_one_pin_out), .pin_oe_q(channel_one_pin_oe),
    .trig_q(one_trig)
  );

  ccp_channel #(.HAS_ADC(1'b1)) u_two (
    .hclk(hclk), .hresetn(hresetn), .pin_in(channel_two_pin_in),
    .first_timer(first_timer), .t2_value(second_timer),
    .t2_fine(second_timer_fine), .t2_wrap(second_timer_wrap),
    .wr_ctrl(wr_two_ctrl), .wr_low(wr_two_low), .wr_high(wr_two_high),
    .wr_flag(wr_flags_two), .wdata(hwdata[7:0]),
    .flag_wbit(hwdata[FLAG_CH2_BIT]), .ctrl_q(two_ctrl), .low_q(two_low),
    .high_q(two_high), .flag_q(two_flag),
    .pin_out_q(channel_two_pin_out), .pin_oe_q(channel_two_pin_oe),
    .trig_q(two_trig)
  );

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign first_timer_reset = first_timer_reset_q;
  assign adc_start = adc_start_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ctrl_zero_a: assert property (take && !hwrite && addr_ok
    && (rd_idx == IDX_ONE_CTRL || rd_idx == IDX_TWO_CTRL)
    |=> hrdata_q[7:6] == 2'b00)
    else $error("control upper bits read nonzero");
  trig_reset_a: assert property ($rose(one_trig)
    |=> first_timer_reset_q)
    else $error("trigger did not reset first timer");
  no_ovf_a: assert property (!first_timer_overflow && !wr_flags_one
    && !t1_flag_q && two_trig |=> !t1_flag_q)
    else $error("trigger set the overflow flag");
  adc_start_a: assert property (two_trig && adc_enabled
    |=> adc_start_q ##1 !adc_start_q)
    else $error("adc start pulse wrong");
endmodule // ccp_unit

`default_nettype wire

// file: testbench/timer_model.sv
// Behavioural timers standing beside the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none

module timer_model #(
  parameter logic [7:0] PERIOD = 8'h0F
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hold,
  input wire logic first_timer_reset,
  output logic [15:0] first_timer,
  output logic first_timer_overflow,
  output logic [7:0] second_timer,
  output logic [1:0] second_timer_fine,
  output logic second_timer_wrap
);
  // First timer counts on the system clock only, never asynchronously
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_timer <= 16'h0000;
      first_timer_overflow <= 1'h0;
    end else begin
      first_timer_overflow <= !first_timer_reset && !hold &&
        (first_timer == 16'hFFFF);
      if (first_timer_reset) begin
        first_timer <= 16'h0000;
      end else if (!hold) begin
        first_timer <= first_timer + 16'h0001;
      end
    end
  end

  // Second timer with two fine bits; wraps after equalling its period
  assign second_timer_wrap = (second_timer == PERIOD) &&
    (second_timer_fine == 2'h3);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {second_timer, second_timer_fine} <= 10'h000;
    end else if (second_timer_wrap) begin
      {second_timer, second_timer_fine} <= 10'h000;
    end else begin
      {second_timer, second_timer_fine} <=
        {second_timer, second_timer_fine} + 10'h001;
    end
  end
endmodule // timer_model

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ccp_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic hold = 1'h0;
  logic adc_en = 1'h1;
  logic pin = 1'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, p1_out, p1_oe, p2_out, p2_oe, ft_rst, adc_go;
  logic [15:0] ft, tgt, tv;
  logic ft_ovf, wrap;
  logic [7:0] st, rd, cb;
  logic [1:0] stf;
  int n_errors = 0;
  int checked = 0;
  int n_rst = 0;
  int n_adc = 0;
  int hi, hi1;
  logic [3:0] cmode [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4,
    MODE_CAP_RISE16};
  int cnt [4] = '{1, 1, 4, 16};
  logic [3:0] kmode [6] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR,
    MODE_CMP_SET, MODE_CMP_TRIG, MODE_CMP_TRIG};
  logic kpin [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
  logic kch [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic kclr [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
  logic [9:0] duty [4] = '{10'h000, 10'h015, 10'h02A, 10'h000};
  logic [3:0] pmode [4] = '{4'hC, 4'hD, 4'hE, 4'hF};

  always #2 hclk = ~hclk;

  ccp_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .first_timer(ft),
    .first_timer_overflow(ft_ovf), .second_timer(st),
    .second_timer_fine(stf), .second_timer_wrap(wrap),
    .adc_enabled(adc_en), .channel_one_pin_in(pin),
    .channel_one_pin_out(p1_out), .channel_one_pin_oe(p1_oe),
    .channel_two_pin_in(pin), .channel_two_pin_out(p2_out),
    .channel_two_pin_oe(p2_oe), .first_timer_reset(ft_rst),
    .adc_start(adc_go));

  timer_model i_tmr (.hclk(hclk), .hresetn(hresetn), .hold(hold),
    .first_timer_reset(ft_rst), .first_timer(ft),
    .first_timer_overflow(ft_ovf), .second_timer(st),
    .second_timer_fine(stf), .second_timer_wrap(wrap));

  always @(posedge hclk) begin
    if (ft_rst === 1'h1) n_rst++;
    if (adc_go === 1'h1) n_adc++;
  end

  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'h1 && i < 16);
  endtask

  // One single transfer; called right after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd, output logic [7:0] rv);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rv = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'h1, idx, d, x);
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx,
      input logic [7:0] exp);
    bus(1'h0, idx, 8'h00, rd);
    chk(nm, {8'h0, rd}, {8'h0, exp});
    chk("read upper", hrdata[31:16], 16'h0000);
    chk("response", {15'h0, hresp}, 16'h0000);
  endtask

  task automatic fchk(input logic [7:0] idx, input int b, input logic e);
    bus(1'h0, idx, 8'h00, rd);
    chk("flag", {15'h0, rd[b]}, {15'h0, e});
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      pin <= 1'h1;
      repeat (6) @(posedge hclk);
      pin <= 1'h0;
      repeat (6) @(posedge hclk);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rchk("ctrl one reset", IDX_ONE_CTRL, 8'h00);
    rchk("ctrl two reset", IDX_TWO_CTRL, 8'h00);
    wr(IDX_TWO_CTRL, 8'hFF);
    rchk("ctrl top bits", IDX_TWO_CTRL, 8'h3F);
    wr(IDX_TWO_CTRL, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    // Capture: timer frozen so the captured count is known
    hold <= 1'h1;
    foreach (cmode[i]) begin
      wr(IDX_ONE_CTRL, {4'h0, cmode[i]});
      pulse(2);
      wr(IDX_ONE_CTRL, 8'h00);
      hold <= 1'h0;
      wr(IDX_ONE_CTRL, {4'h0, cmode[i]});
      hold <= 1'h1;
      wr(IDX_FLAGS_ONE, 8'h00);
      tv = ft;
      chk("pin input", {15'h0, p1_oe}, 16'h0000);
      pulse(cnt[i] - 1);
      fchk(IDX_FLAGS_ONE, FLAG_CH1_BIT, 1'h0);
      pin <= 1'h1;
      repeat (6) @(posedge hclk);
      fchk(IDX_FLAGS_ONE, FLAG_CH1_BIT, cmode[i] != MODE_CAP_FALL);
      pin <= 1'h0;
      repeat (6) @(posedge hclk);
      fchk(IDX_FLAGS_ONE, FLAG_CH1_BIT, 1'h1);
      rchk("capture low", IDX_ONE_LOW, tv[7:0]);
      rchk("capture high", IDX_ONE_HIGH, tv[15:8]);
    end
    // Compare: target a little ahead of the running timer
    hold <= 1'h0;
    foreach (kmode[i]) begin
      cb = kch[i] ? IDX_TWO_LOW : IDX_ONE_LOW;
      n_rst = 0;
      n_adc = 0;
      tgt = ft + 16'h00C8;
      wr(cb + 8'h01, tgt[15:8]);
      wr(cb, tgt[7:0]);
      wr(cb + 8'h02, {4'h0, kmode[i]});
      repeat (300) @(posedge hclk);
      chk("compare pin", {15'h0, (kch[i] ? p2_out : p1_out)},
        {15'h0, kpin[i]});
      chk("pin output", {15'h0, (kch[i] ? p2_oe : p1_oe)}, 16'h0001);
      fchk(kch[i] ? IDX_FLAGS_TWO : IDX_FLAGS_ONE,
        kch[i] ? FLAG_CH2_BIT : FLAG_CH1_BIT, 1'h1);
      chk("timer resets", 16'(n_rst), {15'h0, kmode[i] == MODE_CMP_TRIG});
      chk("adc starts", 16'(n_adc),
        {15'h0, kch[i] && kmode[i] == MODE_CMP_TRIG});
      fchk(IDX_FLAGS_ONE, FLAG_T1_BIT, 1'h0);
      wr(kch[i] ? IDX_FLAGS_TWO : IDX_FLAGS_ONE, 8'h00);
      if (kclr[i]) begin
        wr(cb + 8'h02, 8'h00);
        chk("latch cleared", {15'h0, (kch[i] ? p2_out : p1_out)}, 16'h0);
      end
    end
    // PWM: duty steps, start-of-period writes, high byte read-only
    foreach (duty[i]) begin
      @(posedge hclk iff wrap === 1'h1);
      wr(IDX_ONE_LOW, duty[i][9:2]);
      if (i > 0) rchk("duty held", IDX_ONE_HIGH, duty[i - 1][9:2]);
      wr(IDX_ONE_CTRL, {2'h0, duty[i][1:0], pmode[i]});
      wr(IDX_ONE_HIGH, 8'h77);
      repeat (128) @(posedge hclk);
      rchk("duty latched", IDX_ONE_HIGH, duty[i][9:2]);
      hi = 0;
      repeat (256) begin
        @(posedge hclk);
        if (p1_out === 1'h1) hi++;
      end
      if (duty[i] == 10'h000) chk("zero duty", 16'(hi), 16'h0000);
      if (i == 2) chk("duty step", 16'(hi - hi1), 16'h0054);
      hi1 = hi;
    end
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
